// ==== atm_pkg.sv ====
package atm_pkg;
	// ****************************************
	// Modes and timing
	// ****************************************
	typedef enum logic [2:0] {
		ATM_MODE_INTERNAL,
		ATM_MODE_EXTERNAL,
		ATM_MODE_EXT_START,
		ATM_MODE_SOFTWARE,
		ATM_MODE_EXT_EXPOSURE
	} atm_mode_t;

	localparam int ATM_CLK_PERIOD_NS = 10;
	localparam int ATM_INS_SHORT_NS = 35;
	localparam int ATM_INS_LONG_NS = 135;
	localparam int ATM_SENSOR_OPEN_NS = 300;
	// Latencies are longest times: round down
	localparam int ATM_INS_SHORT_CYC = ATM_INS_SHORT_NS / ATM_CLK_PERIOD_NS;
	localparam int ATM_INS_LONG_CYC = ATM_INS_LONG_NS / ATM_CLK_PERIOD_NS;
	// Settle time is a least time: round up
	localparam int ATM_SENSOR_OPEN_CYC =
		(ATM_SENSOR_OPEN_NS + ATM_CLK_PERIOD_NS - 1) / ATM_CLK_PERIOD_NS;
	localparam int ATM_CNT_W = 16;
	localparam logic [ATM_CNT_W-1:0] ATM_CNT_RESET = 16'h0000;
endpackage

// ==== atm_timing_src.sv ====
`timescale 1ns/1ns
// ****************************************
// Outside timing source model
// ****************************************
module atm_timing_src (
	input wire logic ref_clk,
	output logic ext_trig_pin,
	output logic early_trig_pin
);
	initial
	begin
		ext_trig_pin = 1'b0;
		early_trig_pin = 1'b0;
	end

	// Settle at idle first so the chosen edge is a clean one
	task automatic ext_pulse(input logic idle, input int width);
		@(posedge ref_clk);
		ext_trig_pin <= idle;
		repeat (4) @(posedge ref_clk);
		ext_trig_pin <= ~idle;
		repeat (width) @(posedge ref_clk);
		ext_trig_pin <= idle;
	endtask

	// Optional second pulse per period, which the device must drop
	task automatic early_train(input int cnt, input int width, input int period,
		input logic burst);
		repeat (cnt)
		begin
			@(posedge ref_clk);
			early_trig_pin <= 1'b1;
			repeat (width) @(posedge ref_clk);
			early_trig_pin <= 1'b0;
			if (burst)
			begin
				repeat (3) @(posedge ref_clk);
				early_trig_pin <= 1'b1;
				repeat (2) @(posedge ref_clk);
				early_trig_pin <= 1'b0;
				repeat (period - width - 6) @(posedge ref_clk);
			end
			else
				repeat (period - width - 1) @(posedge ref_clk);
		end
	endtask
endmodule

// ==== atm_trigger_ctrl.sv ====
`timescale 1ns/1ns
// Operation
// - Internal mode: device is timing master, triggers sensor and gate itself.
// - Internal mode: outside equipment synchronised from pulse generator aux outputs.
// - External mode: wait for trigger edge, start sensor and gate together.
// - External trigger edge polarity selectable rising or falling.
// - Armed output high exactly while external or software triggers are accepted.
// - Gate opens 35 ns or 135 ns after trigger, per insertion delay.
// - Sensor treated as not integrating until 300 ns after its trigger.
// - Early sensor trigger may start sensor ahead of external trigger.
// - External start: one external event, then internal timing.
// - Software mode: as external mode, trigger from software command.
// - External exposure mode: exposure and cycle from early sensor trigger.
// - Non-overlap: exposure lasts while early trigger stays asserted.
// - Overlap: exposure equals period between early trigger pulses.
// - Velocimetry: second early trigger pulse of a burst ignored when overlap is enabled.
// - Velocimetry: exposure-active output marks sensor exposure.
// - Velocimetry: each external rising edge starts pulse generator gate.
module atm_trigger_ctrl
	import atm_pkg::*;
#(
	parameter int CNT_W = ATM_CNT_W
)(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire atm_mode_t mode,
	input wire logic acq_enable,
	input wire logic trig_falling,
	input wire logic insertion_long,
	input wire logic overlap_en,
	input wire logic paired_frame_velocimetry_mode,
	input wire logic early_trig_use,
	input wire logic [CNT_W-1:0] internal_exposure,
	input wire logic [CNT_W-1:0] internal_cycle,
	input wire logic [CNT_W-1:0] gate_width,
	input wire logic sw_trigger,
	input wire logic ext_trig_pin,
	input wire logic early_trig_pin,
	output logic armed,
	output logic sensor_trigger,
	output logic sensor_integrating,
	output logic exposure_active,
	output logic delay_pulse_generator_start,
	output logic gate_out,
	output logic sync_out
);
	// ****************************************
	// Pin synchronisers and edge detection
	// ****************************************
	logic ext_s1, ext_s2, ext_s3, early_s1, early_s2, early_s3;
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
			early_s1 <= 1'b0;
			early_s2 <= 1'b0;
			early_s3 <= 1'b0;
		end
		else
		begin
			ext_s1 <= ext_trig_pin;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			early_s1 <= early_trig_pin;
			early_s2 <= early_s1;
			early_s3 <= early_s2;
		end
	end

	logic ext_rise, ext_fall, ext_edge, early_rise, early_fall;
	assign ext_rise = ext_s2 & ~ext_s3;
	assign ext_fall = ~ext_s2 & ext_s3;
	// Velocimetry always uses the rising edge
	assign ext_edge = (trig_falling && !paired_frame_velocimetry_mode) ? ext_fall : ext_rise;
	assign early_rise = early_s2 & ~early_s3;
	assign early_fall = ~early_s2 & early_s3;

	// ****************************************
	// Acquisition sequencing
	// ****************************************
	typedef enum logic [2:0] {
		ATM_ST_IDLE,
		ATM_ST_WAIT_TRIG,
		ATM_ST_EXPOSE,
		ATM_ST_CYCLE,
		ATM_ST_EXT_EXPOSE
	} atm_state_t;

	atm_state_t state, next_state;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic burst_second, next_burst_second;
	logic frame_start, expo;
	logic trig_event;

	// Trigger source for the armed modes
	always_comb
	begin
		unique case (mode)
			ATM_MODE_SOFTWARE: trig_event = sw_trigger;
			default: trig_event = ext_edge;
		endcase
	end

	assign armed = (state == ATM_ST_WAIT_TRIG)
		|| (state == ATM_ST_EXT_EXPOSE && paired_frame_velocimetry_mode);

	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_burst_second = burst_second;
		frame_start = 1'b0;
		expo = 1'b0;
		if (!acq_enable)
		begin
			next_state = ATM_ST_IDLE;
			next_burst_second = 1'b0;
		end
		else
		begin
			unique case (state)
				ATM_ST_IDLE:
				begin
					unique case (mode)
						ATM_MODE_INTERNAL:
						begin
							// Free running, no outside event needed
							next_state = ATM_ST_EXPOSE;
							next_cnt = internal_exposure;
							frame_start = 1'b1;
						end
						ATM_MODE_EXT_EXPOSURE: next_state = ATM_ST_EXT_EXPOSE;
						default: next_state = ATM_ST_WAIT_TRIG;
					endcase
				end
				ATM_ST_WAIT_TRIG:
				begin
					// Events only count here, where armed is high
					if (trig_event)
					begin
						frame_start = 1'b1;
						next_cnt = internal_exposure;
						next_state = ATM_ST_EXPOSE;
					end
				end
				ATM_ST_EXPOSE:
				begin
					expo = 1'b1;
					if (cnt <= 1)
					begin
						next_cnt = (internal_cycle > internal_exposure)
							? internal_cycle - internal_exposure : ATM_CNT_RESET;
						next_state = ATM_ST_CYCLE;
					end
					else
						next_cnt = cnt - 1'b1;
				end
				ATM_ST_CYCLE:
				begin
					if (cnt <= 1)
					begin
						// External start: timing stays internal after first event
						if (mode == ATM_MODE_INTERNAL || mode == ATM_MODE_EXT_START)
						begin
							next_state = ATM_ST_EXPOSE;
							next_cnt = internal_exposure;
							frame_start = 1'b1;
						end
						else
							next_state = ATM_ST_WAIT_TRIG;
					end
					else
						next_cnt = cnt - 1'b1;
				end
				ATM_ST_EXT_EXPOSE:
				begin
					if (overlap_en)
					begin
						expo = 1'b1;
						if (early_rise)
						begin
							if (paired_frame_velocimetry_mode && burst_second)
								next_burst_second = 1'b0;
							else
							begin
								frame_start = 1'b1;
								next_burst_second = paired_frame_velocimetry_mode;
							end
						end
					end
					else
					begin
						expo = early_s2;
						frame_start = early_rise;
					end
				end
				default: next_state = ATM_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= ATM_ST_IDLE;
			cnt <= ATM_CNT_RESET;
			burst_second <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			burst_second <= next_burst_second;
		end
	end

	// ****************************************
	// Sensor settle and gate timing
	// ****************************************
	logic sens_trig, next_sens_trig, expo_q, next_expo_q;
	logic [8:0] settle, next_settle;
	logic [7:0] ins, next_ins;
	logic [CNT_W-1:0] gate_cnt, next_gate_cnt;
	logic gate_start, early_used;

	// Early trigger, when used, has already started the sensor
	assign early_used = early_trig_use && mode == ATM_MODE_EXTERNAL;
	assign gate_start = (state == ATM_ST_EXT_EXPOSE) ? (armed && ext_rise)
		: frame_start;

	always_comb
	begin
		next_sens_trig = early_used ? early_rise : frame_start;
		next_expo_q = expo;
		next_settle = settle;
		if (sens_trig)
			next_settle = 9'(ATM_SENSOR_OPEN_CYC);
		else if (settle != 9'h000)
			next_settle = settle - 1'b1;
		next_ins = ins;
		next_gate_cnt = gate_cnt;
		if (gate_start)
			next_ins = insertion_long ? 8'(ATM_INS_LONG_CYC) : 8'(ATM_INS_SHORT_CYC);
		else if (ins != 8'h00)
		begin
			next_ins = ins - 1'b1;
			if (ins == 8'h01)
				next_gate_cnt = gate_width;
		end
		else if (gate_cnt != ATM_CNT_RESET)
			next_gate_cnt = gate_cnt - 1'b1;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sens_trig <= 1'b0;
			expo_q <= 1'b0;
			settle <= 9'h000;
			ins <= 8'h00;
			gate_cnt <= ATM_CNT_RESET;
		end
		else
		begin
			sens_trig <= next_sens_trig;
			expo_q <= next_expo_q;
			settle <= next_settle;
			ins <= next_ins;
			gate_cnt <= next_gate_cnt;
		end
	end

	assign sensor_trigger = sens_trig;
	assign exposure_active = expo_q;
	assign sensor_integrating = expo_q && settle == 9'h000 && !sens_trig;
	assign delay_pulse_generator_start = (ins == 8'h01);
	assign gate_out = gate_cnt != ATM_CNT_RESET;
	// Aux sync comes from the pulse generator, not from sensor timing
	assign sync_out = gate_out;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_gate_launch;
		gate_start && !insertion_long;
	endsequence

	property p_gate_short;
		@(posedge ref_clk) disable iff (!nrst)
		s_gate_launch |-> ##3 delay_pulse_generator_start;
	endproperty
	a_gate_short: assert property (p_gate_short) else $error("short insertion wrong");

	property p_gate_long;
		@(posedge ref_clk) disable iff (!nrst)
		(gate_start && insertion_long) |-> ##13 delay_pulse_generator_start;
	endproperty
	a_gate_long: assert property (p_gate_long) else $error("long insertion wrong");

	property p_settle;
		@(posedge ref_clk) disable iff (!nrst)
		sensor_trigger |-> !sensor_integrating [*8];
	endproperty
	a_settle: assert property (p_settle) else $error("integrating too early");

	property p_unarmed;
		@(posedge ref_clk) disable iff (!nrst)
		(!armed && mode == ATM_MODE_EXTERNAL && state != ATM_ST_CYCLE) |-> !frame_start;
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("start while unarmed");

	// With the early trigger in use the sensor has already been started
	property p_ext_start;
		@(posedge ref_clk) disable iff (!nrst)
		(armed && ext_edge && mode == ATM_MODE_EXTERNAL && acq_enable && !early_trig_use)
			|=> sensor_trigger;
	endproperty
	a_ext_start: assert property (p_ext_start) else $error("trigger not taken");
	property p_early;
		@(posedge ref_clk) disable iff (!nrst)
		(early_trig_use && mode == ATM_MODE_EXTERNAL && early_rise) |=> sensor_trigger;
	endproperty
	a_early: assert property (p_early) else $error("early trigger not taken");

	property p_sw;
		@(posedge ref_clk) disable iff (!nrst)
		(armed && sw_trigger && mode == ATM_MODE_SOFTWARE && acq_enable) |=> sensor_trigger;
	endproperty
	a_sw: assert property (p_sw) else $error("software trigger not taken");

	property p_nonoverlap;
		@(posedge ref_clk) disable iff (!nrst)
		(state == ATM_ST_EXT_EXPOSE && !overlap_en && acq_enable) |=> exposure_active == $past(early_s2);
	endproperty
	a_nonoverlap: assert property (p_nonoverlap) else $error("exposure not following pulse");

	property p_internal;
		@(posedge ref_clk) disable iff (!nrst)
		(mode == ATM_MODE_INTERNAL && acq_enable && state == ATM_ST_WAIT_TRIG) |-> 1'b0;
	endproperty
	a_internal: assert property (p_internal) else $error("internal mode waiting");

	property p_piv_second;
		@(posedge ref_clk) disable iff (!nrst)
		(state == ATM_ST_EXT_EXPOSE && overlap_en && paired_frame_velocimetry_mode
			&& burst_second && early_rise && acq_enable) |=> !sensor_trigger;
	endproperty
	a_piv_second: assert property (p_piv_second) else $error("second pulse used");
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ns
module testbench
	import atm_pkg::*;
();
	logic ref_clk, nrst, acq_enable, trig_falling, insertion_long, overlap_en, sw_trigger;
	logic paired_frame_velocimetry_mode, early_trig_use, ext_trig_pin, early_trig_pin;
	logic armed, sensor_trigger, sensor_integrating, exposure_active;
	logic delay_pulse_generator_start, gate_out, sync_out;
	logic [15:0] internal_exposure, internal_cycle, gate_width;
	atm_mode_t mode;
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;
	int n, t0;

	atm_trigger_ctrl atm_trigger_ctrl_inst (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.mode(mode),
		.acq_enable(acq_enable),
		.trig_falling(trig_falling),
		.insertion_long(insertion_long),
		.overlap_en(overlap_en),
		.paired_frame_velocimetry_mode(paired_frame_velocimetry_mode),
		.early_trig_use(early_trig_use),
		.internal_exposure(internal_exposure),
		.internal_cycle(internal_cycle),
		.gate_width(gate_width),
		.sw_trigger(sw_trigger),
		.ext_trig_pin(ext_trig_pin),
		.early_trig_pin(early_trig_pin),
		.armed(armed),
		.sensor_trigger(sensor_trigger),
		.sensor_integrating(sensor_integrating),
		.exposure_active(exposure_active),
		.delay_pulse_generator_start(delay_pulse_generator_start),
		.gate_out(gate_out),
		.sync_out(sync_out)
	);
	atm_timing_src atm_timing_src_inst (
		.ref_clk(ref_clk),
		.ext_trig_pin(ext_trig_pin),
		.early_trig_pin(early_trig_pin)
	);

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count++;
			stop_test();
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Bounded wait; n is -1 when the event never came
	task automatic wt(input int w, input int lim);
		logic hit;
		hit = 1'b0;
		n = 0;
		while (!hit && n < lim)
		begin
			@(posedge ref_clk);
			#1;
			n++;
			case (w)
				0: hit = sensor_trigger === 1'b1;
				1: hit = delay_pulse_generator_start === 1'b1;
				2: hit = exposure_active === 1'b0;
				default: hit = sensor_integrating === 1'b1;
			endcase
		end
		if (!hit)
			n = -1;
	endtask

	// Drop to idle first so every scenario starts from a fresh frame
	task automatic cfg(input atm_mode_t m, input logic fl, lg, ov, pv, ea, ac);
		@(posedge ref_clk);
		acq_enable <= 1'b0;
		repeat (4) @(posedge ref_clk);
		mode <= m;
		trig_falling <= fl;
		insertion_long <= lg;
		overlap_en <= ov;
		paired_frame_velocimetry_mode <= pv;
		early_trig_use <= ea;
		acq_enable <= ac;
		repeat (6) @(posedge ref_clk);
		#1;
	endtask

	task automatic gate_chk();
		n = 0;
		@(posedge ref_clk);
		#1;
		while (gate_out === 1'b1 && n < 300)
		begin
			chk(sync_out, gate_out);
			n++;
			@(posedge ref_clk);
			#1;
		end
		chk(n, gate_width);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_internal();
		cfg(ATM_MODE_INTERNAL, 0, 0, 0, 0, 0, 1);
		wt(0, 200);
		chk(n > 0, 1);
		// Sensor pulse is seen one edge after the frame start
		wt(1, 20);
		chk(n, ATM_INS_SHORT_CYC - 1);
		gate_chk();
		wt(0, 200);
		wt(3, 100);
		chk(n >= 30 && n <= 31, 1);
		$display("internal done");
	endtask

	task automatic t_ext(input logic fl, input logic lg, input logic ac);
		cfg(ATM_MODE_EXTERNAL, fl, lg, 0, 0, 0, ac);
		chk(armed, ac);
		fork
			atm_timing_src_inst.ext_pulse(fl, 6);
		join_none
		wt(0, 20);
		if (!ac)
			chk(n, -1);
		else
		begin
			chk(n > 6 && n < 12, 1);
			chk(armed, 0);
			wt(1, 20);
			chk(n, lg ? ATM_INS_LONG_CYC - 1 : ATM_INS_SHORT_CYC - 1);
			gate_chk();
		end
		$display("external done");
	endtask

	task automatic t_sw();
		cfg(ATM_MODE_SOFTWARE, 0, 0, 0, 0, 0, 1);
		@(posedge ref_clk);
		sw_trigger <= 1'b1;
		@(posedge ref_clk);
		sw_trigger <= 1'b0;
		#1;
		chk(sensor_trigger, 1);
		wt(1, 20);
		chk(n, ATM_INS_SHORT_CYC - 1);
		$display("software done");
	endtask

	task automatic t_start();
		cfg(ATM_MODE_EXT_START, 0, 0, 0, 0, 0, 1);
		wt(0, 40);
		chk(n, -1);
		fork
			atm_timing_src_inst.ext_pulse(0, 6);
		join_none
		wt(0, 20);
		chk(n > 0, 1);
		wt(0, 200);
		chk(n > 0, 1);
		$display("external start done");
	endtask

	task automatic t_early();
		cfg(ATM_MODE_EXTERNAL, 0, 0, 0, 0, 1, 1);
		fork
			atm_timing_src_inst.early_train(1, 4, 10, 0);
		join_none
		wt(0, 20);
		chk(n > 0, 1);
		// Outside party holds the gate back until the sensor is open
		repeat (ATM_SENSOR_OPEN_CYC) @(posedge ref_clk);
		fork
			atm_timing_src_inst.ext_pulse(0, 4);
		join_none
		wt(1, 30);
		chk(n > 0, 1);
		$display("early trigger done");
	endtask

	task automatic t_expo(input logic ov, input logic pv);
		cfg(ATM_MODE_EXT_EXPOSURE, 0, 0, ov, pv, 0, 1);
		fork
			atm_timing_src_inst.early_train(2, ov ? 10 : 20, ov ? 60 : 40, pv);
			if (pv)
			begin
				atm_timing_src_inst.ext_pulse(0, 3);
				atm_timing_src_inst.ext_pulse(0, 3);
			end
		join_none
		wt(0, 20);
		t0 = cyc;
		if (!ov)
		begin
			wt(2, 100);
			chk(n, 20);
		end
		else
		begin
			if (pv)
			begin
				chk(exposure_active, 1);
				wt(1, 30);
				chk(n > 0, 1);
			end
			wt(0, 100);
			chk(cyc - t0, 60);
		end
		// Next scenario must not share the pins with a running train
		wait fork;
		$display("exposure trigger done");
	endtask

	initial
	begin
		nrst = 1'b0;
		mode = ATM_MODE_INTERNAL;
		acq_enable = 1'b0;
		trig_falling = 1'b0;
		insertion_long = 1'b0;
		overlap_en = 1'b0;
		paired_frame_velocimetry_mode = 1'b0;
		early_trig_use = 1'b0;
		sw_trigger = 1'b0;
		internal_exposure = 16'h0032;
		internal_cycle = 16'h0050;
		gate_width = 16'h0008;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		t_internal();
		t_ext(0, 0, 1);
		t_ext(1, 1, 1);
		t_ext(0, 0, 0);
		t_sw();
		t_start();
		t_early();
		t_expo(0, 0);
		t_expo(1, 0);
		t_expo(1, 1);
		stop_test();
	end
endmodule
